// *** rtl/sla_alu_top.sv ***
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module sla_alu_top
#(
    parameter int ADDR_W = sla_pkg::APB_ADDR_W
)
(
    input wire logic SYS_CLK, // 200 MHz system clock
    input wire logic SYS_RST, // async reset, active high
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb access phase
    input wire logic PWRITE, // apb direction, high = write
    input wire logic [ADDR_W-1:0] PADDR, // apb byte address
    input wire logic [31:0] PWDATA, // apb write data
    input wire logic [3:0] PSTRB, // apb byte strobes
    output logic [31:0] PRDATA, // apb read data
    output logic PREADY, // apb transfer done
    output logic PSLVERR, // apb error answer
    output logic [7:0] ACC_OUT, // accumulator
    output logic [3:0] FLAGS_OUT, // ov, half carry, carry, zero
    output logic [7:0] MEM_WR_DATA, // byte to write back to data memory
    output logic MEM_WR_STB, // one-cycle memory write-back pulse
    output logic [7:0] FIRST_PORT_OUTPUT_LATCH, // io port data register
    output logic EXEC_DONE // one-cycle pulse per executed command
);
    import sla_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // apb slave timing

    logic pready_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic acc_phase;
    logic xfer_done;
    logic wr_en;
    logic [11:0] addr;
    logic mapped;
    logic [31:0] rd_mux;

    assign acc_phase = PSEL && PENABLE;
    assign xfer_done = acc_phase && pready_r;
    // a write with lane 0 off carries no byte for these registers
    assign wr_en = xfer_done && PWRITE && PSTRB[0];
    assign addr = 12'(PADDR);

    always_comb
    begin
        mapped = 1'b1;
        case (addr)
            OFS_ACC, OFS_FLAGS, OFS_MEM, OFS_IMM, OFS_PORT, OFS_CMD, OFS_STATUS:
                mapped = 1'b1;
            default:
                mapped = 1'b0;
        endcase
    end

    // one wait state, so answer data settles from flops only
    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            pready_r <= 1'b0;
        else
            pready_r <= acc_phase && !pready_r;
    end

    ////////////////////////////////////////////////////////////////////////////
    // command decode

    logic [3:0] cmd_op;
    logic [1:0] cmd_dst;
    logic cmd_src;
    logic cmd_sel;
    logic cmd_legal;
    logic exec;

    assign cmd_op = PWDATA[CMD_OP_LSB +: 4];
    assign cmd_dst = PWDATA[CMD_DST_LSB +: 2];
    assign cmd_src = PWDATA[CMD_SRC_BIT];
    assign cmd_sel = (addr == OFS_CMD);
    assign cmd_legal = sla_legal(cmd_op, cmd_dst);
    assign exec = wr_en && cmd_sel && cmd_legal;

    ////////////////////////////////////////////////////////////////////////////
    // datapath

    logic [7:0] acc_r;
    logic [7:0] mem_r;
    logic [7:0] imm_r;
    logic [7:0] port_r;
    logic flag_z_r;
    logic flag_c_r;
    logic flag_hc_r;
    logic flag_ov_r;

    logic [7:0] target;
    logic [7:0] shift_res;
    logic shift_c;
    logic [7:0] logic_a;
    logic [7:0] logic_b;
    logic [7:0] logic_res;
    logic logic_zero;
    logic [7:0] result;
    logic is_shift;

    // shifts, not and neg act on the destination itself
    assign target = (cmd_dst == DST_MEM) ? mem_r : acc_r;
    assign is_shift = sla_is_shift(cmd_op) || (cmd_op == OP_SWAP);

    sla_shift_unit u_shift
    (
        .op(cmd_op),
        .operand(target),
        .carry_in(flag_c_r),
        .result(shift_res),
        .carry_out(shift_c)
    );

    always_comb
    begin
        logic_a = acc_r;
        logic_b = imm_r;
        if ((cmd_op == OP_NOT) || (cmd_op == OP_NEG))
        begin
            logic_a = target;
        end
        case (cmd_dst)
            DST_MEM: logic_b = mem_r;
            DST_IO: logic_b = port_r;
            default: logic_b = (cmd_src == SRC_MEM) ? mem_r : imm_r;
        endcase
    end

    sla_logic_unit u_logic
    (
        .op(cmd_op),
        .a(logic_a),
        .b(logic_b),
        .result(logic_res),
        .zero(logic_zero)
    );

    assign result = is_shift ? shift_res : logic_res;

    ////////////////////////////////////////////////////////////////////////////
    // accumulator

    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            acc_r <= ACC_RST;
        else if (exec && (cmd_dst == DST_ACC))
            acc_r <= result;
        else if (wr_en && (addr == OFS_ACC))
            acc_r <= PWDATA[7:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // memory operand and write-back

    logic mem_stb_r;

    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            mem_r <= BYTE_RST;
        else if (exec && (cmd_dst == DST_MEM))
            mem_r <= result;
        else if (wr_en && (addr == OFS_MEM))
            mem_r <= PWDATA[7:0];
    end

    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            mem_stb_r <= 1'b0;
        else
            mem_stb_r <= exec && (cmd_dst == DST_MEM);
    end

    ////////////////////////////////////////////////////////////////////////////
    // immediate and port latch

    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            imm_r <= BYTE_RST;
        else if (wr_en && (addr == OFS_IMM))
            imm_r <= PWDATA[7:0];
    end

    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            port_r <= BYTE_RST;
        else if (exec && (cmd_dst == DST_IO))
            port_r <= result;
        else if (wr_en && (addr == OFS_PORT))
            port_r <= PWDATA[7:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // flags: shifts touch carry only, swap and io xor touch none

    logic upd_c;
    logic upd_z;

    assign upd_c = exec && sla_is_shift(cmd_op);
    assign upd_z = exec && !is_shift && (cmd_dst != DST_IO);

    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            flag_z_r <= FLAGS_RST[FLG_Z];
        end
        else if (upd_z)
        begin
            flag_z_r <= logic_zero;
        end
        else if (wr_en && (addr == OFS_FLAGS))
        begin
            flag_z_r <= PWDATA[FLG_Z];
        end
    end

    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            flag_c_r <= FLAGS_RST[FLG_C];
        end
        else if (upd_c)
        begin
            flag_c_r <= shift_c;
        end
        else if (wr_en && (addr == OFS_FLAGS))
        begin
            flag_c_r <= PWDATA[FLG_C];
        end
    end

    // no operation here alters these two; only software loads them
    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            flag_hc_r <= FLAGS_RST[FLG_HC];
            flag_ov_r <= FLAGS_RST[FLG_OV];
        end
        else if (wr_en && (addr == OFS_FLAGS))
        begin
            flag_hc_r <= PWDATA[FLG_HC];
            flag_ov_r <= PWDATA[FLG_OV];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status

    logic [3:0] last_op_r;
    logic illegal_r;
    logic [7:0] exec_cnt_r;
    logic done_r;

    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            last_op_r <= 4'h0;
            illegal_r <= 1'b0;
        end
        else if (wr_en && cmd_sel)
        begin
            last_op_r <= cmd_op;
            illegal_r <= !cmd_legal;
        end
    end

    // counter wraps; software compares snapshots
    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            exec_cnt_r <= 8'h00;
        else if (exec)
            exec_cnt_r <= 8'(exec_cnt_r + 8'h01);
    end

    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            done_r <= 1'b0;
        else
            done_r <= exec;
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux and answer

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (addr)
            OFS_ACC: rd_mux[7:0] = acc_r;
            OFS_FLAGS:
            begin
                rd_mux[FLG_Z] = flag_z_r;
                rd_mux[FLG_C] = flag_c_r;
                rd_mux[FLG_HC] = flag_hc_r;
                rd_mux[FLG_OV] = flag_ov_r;
            end
            OFS_MEM: rd_mux[7:0] = mem_r;
            OFS_IMM: rd_mux[7:0] = imm_r;
            OFS_PORT: rd_mux[7:0] = port_r;
            OFS_STATUS:
            begin
                rd_mux[3:0] = last_op_r;
                rd_mux[STS_ILLEGAL_BIT] = illegal_r;
                rd_mux[STS_CNT_LSB +: 8] = exec_cnt_r;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // command register reads as zero; it has no storage
    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
        else if (acc_phase && !pready_r)
        begin
            prdata_r <= PWRITE ? 32'h0000_0000 : rd_mux;
            pslverr_r <= !mapped || (PWRITE && cmd_sel && PSTRB[0] && !cmd_legal);
        end
        else
        begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign PRDATA = prdata_r;
    assign PREADY = pready_r;
    assign PSLVERR = pslverr_r;
    assign ACC_OUT = acc_r;
    assign FLAGS_OUT = {flag_ov_r, flag_hc_r, flag_c_r, flag_z_r};
    assign MEM_WR_DATA = mem_r;
    assign MEM_WR_STB = mem_stb_r;
    assign FIRST_PORT_OUTPUT_LATCH = port_r;
    assign EXEC_DONE = done_r;

endmodule
`default_nettype wire

// *** rtl/sla_pkg.sv ***
// What this block does
// - right shift of accumulator fills bit 7 with zero, old bit 0 to carry
// - right rotate through carry: old carry to bit 7, old bit 0 to carry
// - right shift and rotate also act on memory byte, carry only
// - left shift of accumulator fills bit 0 with zero, old bit 7 to carry
// - left rotate through carry: old carry to bit 0, old bit 7 to carry
// - left shift and rotate also act on memory byte, carry only
// - nibble swap exchanges accumulator halves, no flag changes
// - AND with immediate or memory into accumulator, or into memory; zero only
// - OR with immediate or memory into accumulator, or into memory; zero only
// - XOR with immediate or memory into accumulator, or into memory; zero only
// - XOR of accumulator into port output latch changes no flag
// - complement of accumulator or memory byte updates zero only
// - two's complement of accumulator or memory byte updates zero only
package sla_pkg;

localparam int APB_ADDR_W = 12;
localparam int DATA_W = 8;

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
localparam logic [11:0] OFS_ACC = 12'h000;
localparam logic [11:0] OFS_FLAGS = 12'h004;
localparam logic [11:0] OFS_MEM = 12'h008;
localparam logic [11:0] OFS_IMM = 12'h00c;
localparam logic [11:0] OFS_PORT = 12'h010;
localparam logic [11:0] OFS_CMD = 12'h014;
localparam logic [11:0] OFS_STATUS = 12'h018;

// flag register bit positions
localparam int FLG_Z = 0;
localparam int FLG_C = 1;
localparam int FLG_HC = 2;
localparam int FLG_OV = 3;

// command register fields
localparam int CMD_OP_LSB = 0;
localparam int CMD_DST_LSB = 4;
localparam int CMD_SRC_BIT = 6;

// status register fields
localparam int STS_ILLEGAL_BIT = 4;
localparam int STS_CNT_LSB = 8;

// reset values
localparam logic [7:0] ACC_RST = 8'h00;
localparam logic [3:0] FLAGS_RST = 4'h0;
localparam logic [7:0] BYTE_RST = 8'h00;

////////////////////////////////////////////////////////////////////////////////
typedef enum logic [3:0] {
    OP_SHR, OP_RRC, OP_SHL, OP_RLC, OP_SWAP,
    OP_AND, OP_OR, OP_XOR, OP_NOT, OP_NEG
} sla_op_e;

typedef enum logic [1:0] {DST_ACC, DST_MEM, DST_IO} sla_dst_e;

typedef enum logic {SRC_IMM, SRC_MEM} sla_src_e;

function automatic logic sla_is_zero(input logic [7:0] v);
    return v == 8'h00;
endfunction

// which destination each operation accepts
function automatic logic sla_legal(input logic [3:0] op, input logic [1:0] dst);
    logic ok;
    ok = 1'b0;
    case (op)
        OP_SHR, OP_RRC, OP_SHL, OP_RLC, OP_AND, OP_OR, OP_NOT, OP_NEG:
            ok = (dst == DST_ACC) || (dst == DST_MEM);
        OP_SWAP:
            ok = (dst == DST_ACC);
        OP_XOR:
            ok = (dst == DST_ACC) || (dst == DST_MEM) || (dst == DST_IO);
        default:
            ok = 1'b0;
    endcase
    return ok;
endfunction

function automatic logic sla_is_shift(input logic [3:0] op);
    return (op == OP_SHR) || (op == OP_RRC) || (op == OP_SHL) || (op == OP_RLC);
endfunction

endpackage

// *** rtl/sla_shift_unit.sv ***
`timescale 1ns/100ps
`default_nettype none
module sla_shift_unit
(
    input wire logic [3:0] op, // operation code
    input wire logic [7:0] operand, // accumulator or memory byte
    input wire logic carry_in, // current carry flag
    output logic [7:0] result, // shifted byte
    output logic carry_out // new carry
);
    import sla_pkg::*;

    always_comb
    begin
        result = operand;
        carry_out = carry_in;
        case (op)
            OP_SHR:
            begin
                result = {1'b0, operand[7:1]};
                carry_out = operand[0];
            end
            OP_RRC:
            begin
                result = {carry_in, operand[7:1]};
                carry_out = operand[0];
            end
            OP_SHL:
            begin
                result = {operand[6:0], 1'b0};
                carry_out = operand[7];
            end
            OP_RLC:
            begin
                result = {operand[6:0], carry_in};
                carry_out = operand[7];
            end
            OP_SWAP:
                result = {operand[3:0], operand[7:4]};
            default:
                result = operand;
        endcase
    end
endmodule
`default_nettype wire

// *** rtl/sla_logic_unit.sv ***
`timescale 1ns/100ps
`default_nettype none
module sla_logic_unit
(
    input wire logic [3:0] op, // operation code
    input wire logic [7:0] a, // accumulator, or target of not/neg
    input wire logic [7:0] b, // second operand
    output logic [7:0] result, // logic result
    output logic zero // result is zero
);
    import sla_pkg::*;

    always_comb
    begin
        case (op)
            OP_AND: result = a & b;
            OP_OR: result = a | b;
            OP_XOR: result = a ^ b;
            OP_NOT: result = ~a;
            OP_NEG: result = 8'((~a) + 8'h01);
            default: result = a;
        endcase
        zero = sla_is_zero(result);
    end
endmodule
`default_nettype wire

// *** bench/sla_chk_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
module sla_chk
import sla_pkg::*;
#(
    parameter int ADDR_W = APB_ADDR_W
)
(
    input wire logic SYS_CLK, // clock
    input wire logic SYS_RST, // reset
    input wire logic PSEL, // select
    input wire logic PENABLE, // access
    input wire logic PWRITE, // write
    input wire logic [ADDR_W-1:0] PADDR, // address
    input wire logic [31:0] PWDATA, // wdata
    input wire logic [3:0] PSTRB, // strobes
    input wire logic [31:0] PRDATA, // rdata
    input wire logic PREADY, // ready
    input wire logic PSLVERR, // error
    input wire logic [7:0] ACC_OUT, // acc
    input wire logic [3:0] FLAGS_OUT, // flags
    input wire logic [7:0] MEM_WR_DATA, // mem
    input wire logic MEM_WR_STB, // mem pulse
    input wire logic [7:0] FIRST_PORT_OUTPUT_LATCH, // port
    input wire logic EXEC_DONE // done
);
logic go;
logic [3:0] op;
logic [1:0] dst, d_q;
logic [7:0] a_q, s_q, p_q, res;
logic [3:0] f_q;
assign op = PWDATA[3:0];
assign dst = PWDATA[5:4];
assign go = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0] && !PSLVERR && PADDR == ADDR_W'(OFS_CMD);
assign res = (d_q == 2'd1) ? MEM_WR_DATA : ACC_OUT;
// operands as they stood when the command was taken
always_ff @(posedge SYS_CLK)
begin
    d_q <= dst;
    a_q <= ACC_OUT;
    s_q <= (dst == 2'd1) ? MEM_WR_DATA : ACC_OUT;
    p_q <= FIRST_PORT_OUTPUT_LATCH;
    f_q <= FLAGS_OUT;
end
////////////////////////////////////////////////////////////////////////////////
default clocking cb @(posedge SYS_CLK);
endclocking
default disable iff (SYS_RST);
AST_RDY_WAIT: assert property (PSEL && !PENABLE |-> ##2 PREADY) else $error("ready late");
AST_RDY_ONE: assert property (PREADY |=> !PREADY) else $error("ready held");
AST_DONE: assert property (go |=> EXEC_DONE && MEM_WR_STB == (d_q == 2'd1))
    else $error("no done pulse");
AST_SHR: assert property (go && op == 4'h0 |=> res == {1'b0, s_q[7:1]} && FLAGS_OUT == {f_q[3:2], s_q[0], f_q[0]})
    else $error("shr");
AST_RRC: assert property (go && op == 4'h1 |=> res == {f_q[1], s_q[7:1]} && FLAGS_OUT == {f_q[3:2], s_q[0], f_q[0]})
    else $error("rrc");
AST_SHL: assert property (go && op == 4'h2 |=> res == {s_q[6:0], 1'b0} && FLAGS_OUT == {f_q[3:2], s_q[7], f_q[0]})
    else $error("shl");
AST_RLC: assert property (go && op == 4'h3 |=> res == {s_q[6:0], f_q[1]} && FLAGS_OUT == {f_q[3:2], s_q[7], f_q[0]})
    else $error("rlc");
AST_SWAP: assert property (go && op == 4'h4 |=> ACC_OUT == {a_q[3:0], a_q[7:4]} && $stable(FLAGS_OUT))
    else $error("swap");
AST_XIO: assert property (go && op == 4'h7 && dst == 2'd2 |=> FIRST_PORT_OUTPUT_LATCH == (a_q ^ p_q) && FLAGS_OUT == f_q)
    else $error("xor to port");
AST_ZERO: assert property (go && op > 4'h4 && op < 4'ha && dst != 2'd2 |=> FLAGS_OUT == {f_q[3:1], res == 8'h00})
    else $error("zero flag");
AST_NEG: assert property (go && op == 4'h9 |=> res == ~s_q + 8'h01)
    else $error("neg");
cover property (go && dst == 2'd1);
cover property (go && op == 4'h7 && dst == 2'd2);
cover property (PREADY && PSLVERR);
endmodule
bind sla_alu_top sla_chk #(.ADDR_W(ADDR_W)) u_chk (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .ACC_OUT(ACC_OUT), .FLAGS_OUT(FLAGS_OUT), .MEM_WR_DATA(MEM_WR_DATA),
    .MEM_WR_STB(MEM_WR_STB), .FIRST_PORT_OUTPUT_LATCH(FIRST_PORT_OUTPUT_LATCH), .EXEC_DONE(EXEC_DONE));
`default_nettype wire

// *** bench/sla_alu_top_test.sv ***
`timescale 1ns/100ps
`default_nettype none
module sla_alu_top_test;
import sla_pkg::*;
logic clk, rst, psel, pen, pwr, rdy, err, done, stb, e;
logic [11:0] paddr;
logic [31:0] pwdata, prdata, rd;
logic [3:0] pstrb, flags;
logic [7:0] acc, mdat, port;
int failures, tests_run;
sla_alu_top DUT (
    .SYS_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
    .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(rdy), .PSLVERR(err), .ACC_OUT(acc),
    .FLAGS_OUT(flags), .MEM_WR_DATA(mdat), .MEM_WR_STB(stb), .FIRST_PORT_OUTPUT_LATCH(port), .EXEC_DONE(done)
);
initial
begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
end
////////////////////////////////////////////////////////////////////////////////
task give_verdict;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
endtask
task automatic check(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x)
    begin
        failures++;
        $display("unexpected at %0t: seen %h expected %h", $time, s, x);
    end
endtask
// no fixed latency assumed: wait on ready, bounded
task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do
    begin
        @(posedge clk);
        n++;
    end
    while (rdy !== 1'b1 && n < 16);
    rd = prdata;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
    #1;
    if (n >= 16)
    begin
        failures++;
        give_verdict;
    end
endtask
task automatic wr(input logic [11:0] a, input logic [7:0] v);
    apb(1'b1, a, {24'h0, v}, 4'hf);
    check(e, 0);
endtask
task automatic rchk(input logic [11:0] a, input logic [7:0] x);
    apb(1'b0, a, 0, 4'hf);
    check(rd, {24'h0, x});
    check(e, 0);
endtask
task automatic cmd(input logic [3:0] o, input logic [1:0] d, input logic s, input logic bad);
    apb(1'b1, OFS_CMD, {25'h0, s, d, o}, 4'hf);
    check(e, bad);
    check(done, !bad);
    check(stb, !bad && d == 2'd1);
endtask
////////////////////////////////////////////////////////////////////////////////
task automatic t_reset;
    check({acc, flags, mdat, port, done, stb}, 0);
    for (int a = 0; a < 28; a += 4)
        rchk(12'(a), 8'h00);
    apb(1'b0, 12'h01c, 0, 4'hf);
    check(e, 1);
    check(rd, 0);
endtask
task automatic t_shift;
    logic [7:0] x, r;
    logic c, co;
    for (int i = 0; i < 32; i++)
    begin
        x = i[4] ? 8'h42 : 8'h81;
        c = i[3];
        wr(OFS_ACC, x);
        wr(OFS_MEM, x);
        wr(OFS_FLAGS, {6'h2, c, 1'b1});
        cmd(4'(i[2:1]), {1'b0, i[0]}, 1'b0, 1'b0);
        case (i[2:1])
            0: r = {1'b0, x[7:1]};
            1: r = {c, x[7:1]};
            2: r = {x[6:0], 1'b0};
            default: r = {x[6:0], c};
        endcase
        co = i[2] ? x[7] : x[0];
        rchk(i[0] ? OFS_MEM : OFS_ACC, r);
        rchk(i[0] ? OFS_ACC : OFS_MEM, x);
        rchk(OFS_FLAGS, {6'h2, co, 1'b1});
    end
endtask
task automatic t_logic;
    logic [7:0] a, m, n, b, t, r;
    logic [3:0] o;
    for (int i = 0; i < 40; i++)
    begin
        o = 4'(5 + (i / 4) % 5);
        // memory targets and not/neg take no source select
        if (i[0] && (i[1] || o > 4'h7))
            continue;
        a = i < 20 ? 8'h38 : 8'h00;
        m = i < 20 ? 8'h0f : 8'hff;
        n = i < 20 ? 8'hc7 : 8'hff;
        b = (i[0] || i[1]) ? m : n;
        t = i[1] ? m : a;
        wr(OFS_ACC, a);
        wr(OFS_MEM, m);
        wr(OFS_IMM, n);
        wr(OFS_FLAGS, 8'h0e);
        cmd(o, {1'b0, i[1]}, i[0], 1'b0);
        case (o)
            5: r = a & b;
            6: r = a | b;
            7: r = a ^ b;
            8: r = ~t;
            default: r = -t;
        endcase
        rchk(i[1] ? OFS_MEM : OFS_ACC, r);
        rchk(OFS_FLAGS, {7'h7, r == 8'h00});
    end
endtask
task automatic t_misc;
    logic [7:0] base;
    apb(1'b0, OFS_STATUS, 0, 4'hf);
    base = rd[15:8];
    wr(OFS_ACC, 8'h3c);
    wr(OFS_FLAGS, 8'h0a);
    cmd(4'h4, 2'd0, 1'b0, 1'b0);
    rchk(OFS_ACC, 8'hc3);
    rchk(OFS_FLAGS, 8'h0a);
    wr(OFS_PORT, 8'h55);
    wr(OFS_ACC, 8'h0f);
    // zero preset with nonzero result: must survive
    wr(OFS_FLAGS, 8'h05);
    cmd(4'h7, 2'd2, 1'b0, 1'b0);
    check(port, 8'h5a);
    rchk(OFS_FLAGS, 8'h05);
    cmd(4'h4, 2'd1, 1'b0, 1'b1);
    cmd(4'h0, 2'd2, 1'b0, 1'b1);
    cmd(4'ha, 2'd0, 1'b0, 1'b1);
    cmd(4'h5, 2'd3, 1'b0, 1'b1);
    apb(1'b0, OFS_STATUS, 0, 4'hf);
    check(rd & 32'h1f, 32'h15);
    // only the swap and the port xor count; refused commands do not
    check(rd[15:8], 8'(base + 8'h02));
    apb(1'b1, 12'h01c, 32'h1, 4'hf);
    check(e, 1);
    apb(1'b1, OFS_ACC, 32'h77, 4'h0);
    check(e, 0);
    rchk(OFS_ACC, 8'h0f);
    rchk(OFS_PORT, 8'h5a);
    rchk(OFS_FLAGS, 8'h05);
    rchk(OFS_CMD, 8'h00);
endtask
initial
begin
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = '0;
    failures = 0;
    tests_run = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_shift;
    t_logic;
    t_misc;
    give_verdict;
end
endmodule
`default_nettype wire
